// file: hw/ats_pkg.sv
// Constants, types and carriers of the analyzer trigger sequencer.
// Assumes a front end that delivers probe samples on the system clock.
//
// Overview of operation
// - Sixteen word recognizers; splits 16/0, 13/1, 10/2, 7/3, 4/4 words/ranges.
// - Range value runs from top_probe_group down to clock_group_zero as one word.
// - Absent groups drop out of range value; merged master holds upper part.
// - Glitch detect enabled per group, active only with asynchronous clocking.
// - Setup/hold check per group, window -8 ns to +8 ns in 0.5 ns steps.
// - Transition detect per group flags change versus previous valid sample.
// - Two 51-bit counter/timers, each an event counter or elapsed timer.
// - Backplane trigger input triggers main and high-res acquisition if untriggered.
// - At most sixteen trigger resources active, counter/timers not counted.
// - Sixteen trigger states, one evaluation and step per valid sample.
// - A state action can assert the main acquisition trigger.
// - Main trigger position programmable to any sample, on 4 ns boundaries.
// - A state action can increment a counter/timer used as counter.
// - A state action can start or stop a counter/timer used as timer.
// - Clock channels enabled separately, edge rise/fall/both; levels stored.
// - Transitional storage writes a sample only when it differs from previous.
// - Timer reset clears the value but keeps its started or stopped condition.
// - Each glitch, setup/hold or transition detector kind in use costs one word.
// - Counter/timers support set, reset and test; reset has no latency.
package ats_pkg;
    // ============================================================
    // Sizes
    localparam int N_GRP     = 24;
    localparam int GRP_W     = 8;
    localparam int DW        = N_GRP * GRP_W;
    localparam int RW        = 2 * DW;
    localparam int N_WR      = 16;
    localparam int N_RNG_MAX = 4;
    localparam int RNG_COST  = 3;
    localparam int N_RES_MAX = 16;
    localparam int N_ST      = 16;
    localparam int N_CT      = 2;
    localparam int CT_W      = 51;
    localparam int N_CK      = 4;
    // ============================================================
    // Timing
    localparam int SH_SPAN_PS   = 8000;
    localparam int SH_STEP_PS   = 500;
    localparam int SH_CODE_MAX  = 2 * SH_SPAN_PS / SH_STEP_PS;
    localparam int POS_STEP_PS  = 4000;
    // ============================================================
    // Event selector codes
    localparam logic [4:0] EV_RNG0  = 5'h10;
    localparam logic [4:0] EV_GLT   = 5'h14;
    localparam logic [4:0] EV_SH    = 5'h15;
    localparam logic [4:0] EV_TRN   = 5'h16;
    localparam logic [4:0] EV_SIG1  = 5'h17;
    localparam logic [4:0] EV_SIG2  = 5'h18;
    localparam logic [4:0] EV_CT0   = 5'h19;
    localparam logic [4:0] EV_TRUE  = 5'h1f;
    // ============================================================
    // Types
    typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH} ats_edge_t;
    typedef enum logic [1:0] {A_IDLE, A_RUN, A_POST, A_DONE} ats_phase_t;
    typedef struct packed {
        logic [N_CT-1:0] inc;
        logic [N_CT-1:0] start;
        logic [N_CT-1:0] stop;
        logic [N_CT-1:0] set;
        logic [N_CT-1:0] rst;
        logic            trig;
    } ats_act_t;
    typedef struct packed {
        logic [4:0] evt_sel;
        logic [3:0] go_to;
        ats_act_t   act;
    } ats_prog_t;
    typedef struct packed {
        logic [DW-1:0] value;
        logic [DW-1:0] mask;
    } ats_word_t;
    typedef struct packed {
        logic [RW-1:0] lo;
        logic [RW-1:0] hi;
    } ats_rng_t;
    typedef struct packed {
        logic [5:0] setup;
        logic [5:0] hold;
    } ats_sh_t;
endpackage

// file: hw/ats_trigger_sequencer.sv
// Trigger sequencer: recognizers, detectors, state machine, counter/timers.
// Assumes probe samples, glitch and violation flags arrive synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ats_trigger_sequencer #(
    parameter int POS_W = 16
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // Sample input
    input  wire logic [ats_pkg::DW-1:0] smp_data,
    input  wire logic                   smp_stb,
    input  wire logic [ats_pkg::DW-1:0] slave_data,
    input  wire logic [ats_pkg::N_GRP-1:0] glitch_flag,
    input  wire logic [ats_pkg::N_GRP-1:0] sh_flag,
    // Configuration
    input  wire logic                   async_mode,
    input  wire logic                   merged,
    input  wire logic [ats_pkg::N_GRP-1:0] grp_present,
    input  wire logic [ats_pkg::N_CK-1:0]  ck_en,
    input  wire ats_pkg::ats_edge_t     ck_edge [ats_pkg::N_CK],
    input  wire logic [2:0]             n_range,
    input  wire ats_pkg::ats_word_t     word_cfg [ats_pkg::N_WR],
    input  wire ats_pkg::ats_rng_t      rng_cfg [ats_pkg::N_RNG_MAX],
    input  wire logic [ats_pkg::N_GRP-1:0] glitch_en,
    input  wire logic [ats_pkg::N_GRP-1:0] sh_en,
    input  wire ats_pkg::ats_sh_t       sh_win [ats_pkg::N_GRP],
    input  wire logic [ats_pkg::N_GRP-1:0] trans_en,
    input  wire logic [1:0]             sig_use,
    input  wire ats_pkg::ats_prog_t     prog [ats_pkg::N_ST],
    input  wire logic [POS_W-1:0]       trig_pos,
    input  wire logic                   trans_store,
    input  wire logic [ats_pkg::N_CT-1:0] ct_timer,
    input  wire logic [ats_pkg::CT_W-1:0] ct_preset [ats_pkg::N_CT],
    input  wire logic [ats_pkg::CT_W-1:0] ct_limit [ats_pkg::N_CT],
    // Control and backplane
    input  wire logic                   arm,
    input  wire logic [1:0]             sig_in,
    input  wire logic                   trig_in,
    // Status and outputs
    output logic                        cfg_err,
    output logic                        main_trig,
    output logic                        hr_trig,
    output logic                        acq_done,
    output logic [3:0]                  trig_state,
    output logic                        store,
    output logic [ats_pkg::DW-1:0]      store_data,
    output logic [ats_pkg::CT_W-1:0]    ct_val [ats_pkg::N_CT]
);
    import ats_pkg::*;

    if (POS_W < 1 || POS_W > 32) begin : g_chk
        $error("POS_W must lie in 1..32");
    end

    // ============================================================
    // Sample qualification
    logic [DW-1:0]   data_m;
    logic [DW-1:0]   prev_r;
    logic [DW-1:0]   prev_nxt;
    logic [N_CK-1:0] ck_prev_r;
    logic [N_CK-1:0] ck_prev_nxt;
    logic [N_CK-1:0] ck_hit;
    logic            valid;
    logic [RW-1:0]   rng_val;

    for (genvar g = 0; g < N_GRP; g++) begin : g_mask
        // Absent groups read as zero so they drop out of every compare
        assign data_m[g*GRP_W +: GRP_W] =
            smp_data[g*GRP_W +: GRP_W] & {GRP_W{grp_present[g]}};
    end

    for (genvar k = 0; k < N_CK; k++) begin : g_ck
        logic rise;
        logic fall;
        assign rise = smp_data[k] & ~ck_prev_r[k];
        assign fall = ~smp_data[k] & ck_prev_r[k];
        always_comb begin
            case (ck_edge[k])
                EDGE_RISE: ck_hit[k] = ck_en[k] & rise;
                EDGE_FALL: ck_hit[k] = ck_en[k] & fall;
                EDGE_BOTH: ck_hit[k] = ck_en[k] & (rise | fall);
                default:   ck_hit[k] = 1'b0;
            endcase
        end
    end

    assign valid = async_mode ? smp_stb : |ck_hit;
    // Slave occupies the low half; unmerged modules pad the top with zero
    assign rng_val = merged ? {data_m, slave_data} : {{DW{1'b0}}, data_m};

    // ============================================================
    // Resource accounting
    logic [4:0] det_cnt;
    logic [4:0] used;
    logic [4:0] avail;
    logic       sh_bad;

    always_comb begin
        sh_bad = 1'b0;
        for (int g = 0; g < N_GRP; g++) begin
            if (sh_en[g] && (sh_win[g].setup > 6'(SH_CODE_MAX) ||
                             sh_win[g].hold > 6'(SH_CODE_MAX))) begin
                sh_bad = 1'b1;
            end
        end
    end

    // Every detector kind in use takes one word recognizer away
    assign det_cnt = 5'(|glitch_en) + 5'(|sh_en) + 5'(|trans_en)
                   + 5'(sig_use[0]) + 5'(sig_use[1]);
    assign used    = 5'(n_range) * 5'(RNG_COST) + det_cnt;
    assign cfg_err = (n_range > 3'(N_RNG_MAX)) || (used > 5'(N_RES_MAX))
                   || sh_bad;
    assign avail   = cfg_err ? 5'h00 : 5'(N_RES_MAX) - used;

    // ============================================================
    // Recognizers and detectors
    logic [N_WR-1:0]      wr_hit;
    logic [N_RNG_MAX-1:0] rng_hit;
    logic [N_GRP-1:0]     glt_g;
    logic [N_GRP-1:0]     sh_g;
    logic [N_GRP-1:0]     trn_g;
    logic [N_CT-1:0]      ct_hit;
    logic [31:0]          ev;

    for (genvar i = 0; i < N_WR; i++) begin : g_wr
        assign wr_hit[i] = (5'(i) < avail) &&
            (((data_m ^ word_cfg[i].value) & word_cfg[i].mask) == '0);
    end

    for (genvar k = 0; k < N_RNG_MAX; k++) begin : g_rng
        assign rng_hit[k] = (3'(k) < n_range) && !cfg_err &&
            (rng_val >= rng_cfg[k].lo) && (rng_val <= rng_cfg[k].hi);
    end

    for (genvar g = 0; g < N_GRP; g++) begin : g_det
        // Glitches only mean anything while sampling asynchronously
        assign glt_g[g] = glitch_en[g] & async_mode & glitch_flag[g];
        assign sh_g[g]  = sh_en[g] & ~async_mode & sh_flag[g];
        assign trn_g[g] = trans_en[g] &
            (data_m[g*GRP_W +: GRP_W] != prev_r[g*GRP_W +: GRP_W]);
    end

    always_comb begin
        ev                       = '0;
        ev[N_WR-1:0]             = wr_hit;
        ev[EV_RNG0 +: N_RNG_MAX] = rng_hit;
        ev[EV_GLT]               = |glt_g;
        ev[EV_SH]                = |sh_g;
        ev[EV_TRN]               = |trn_g;
        ev[EV_SIG1]              = sig_use[0] & sig_in[0];
        ev[EV_SIG2]              = sig_use[1] & sig_in[1];
        ev[EV_CT0 +: N_CT]       = ct_hit;
        ev[EV_TRUE]              = 1'b1;
    end

    // ============================================================
    // Trigger state machine
    ats_phase_t     ph_r;
    ats_phase_t     ph_nxt;
    logic [3:0]     st_r;
    logic [3:0]     st_nxt;
    logic           mt_r;
    logic           mt_nxt;
    logic           ht_r;
    logic           ht_nxt;
    logic [POS_W-1:0] post_r;
    logic [POS_W-1:0] post_nxt;
    logic           st_on;
    ats_act_t       act;
    logic           do_trig;

    assign st_on   = (ph_r == A_RUN) && valid &&
                     ev[prog[st_r].evt_sel];
    assign act     = st_on ? prog[st_r].act : '0;
    assign do_trig = (act.trig || trig_in) && !mt_r;

    always_comb begin
        ph_nxt   = ph_r;
        st_nxt   = st_r;
        mt_nxt   = mt_r;
        ht_nxt   = ht_r;
        post_nxt = post_r;
        if (ph_r != A_IDLE && trig_in && !ht_r) begin
            ht_nxt = 1'b1;
        end
        case (ph_r)
            A_IDLE: begin
                if (arm && !cfg_err) begin
                    ph_nxt = A_RUN;
                    st_nxt = 4'h0;
                    mt_nxt = 1'b0;
                    ht_nxt = 1'b0;
                end
            end
            A_RUN: begin
                if (st_on) begin
                    st_nxt = prog[st_r].go_to;
                end
                if (do_trig) begin
                    mt_nxt   = 1'b1;
                    post_nxt = trig_pos;
                    ph_nxt   = A_POST;
                end
            end
            A_POST: begin
                // Position counts valid samples after the trigger sample
                if (valid) begin
                    if (post_r == '0) begin
                        ph_nxt = A_DONE;
                    end else begin
                        post_nxt = post_r - 1'b1;
                    end
                end
            end
            A_DONE: begin
                if (arm && !cfg_err) begin
                    ph_nxt = A_RUN;
                    st_nxt = 4'h0;
                    mt_nxt = 1'b0;
                    ht_nxt = 1'b0;
                end
            end
            default: ph_nxt = A_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ph_r   <= A_IDLE;
            st_r   <= 4'h0;
            mt_r   <= 1'b0;
            ht_r   <= 1'b0;
            post_r <= '0;
        end else begin
            ph_r   <= ph_nxt;
            st_r   <= st_nxt;
            mt_r   <= mt_nxt;
            ht_r   <= ht_nxt;
            post_r <= post_nxt;
        end
    end

    assign main_trig  = mt_r;
    assign hr_trig    = ht_r;
    assign acq_done   = (ph_r == A_DONE);
    assign trig_state = st_r;

    // ============================================================
    // Sample history and storage
    logic          differs;
    logic          store_nxt;
    logic          store_r;
    logic [DW-1:0] sdata_r;
    logic [DW-1:0] sdata_nxt;

    assign differs = (data_m != prev_r);

    always_comb begin
        prev_nxt    = valid ? data_m : prev_r;
        ck_prev_nxt = smp_data[N_CK-1:0];
        store_nxt   = valid && (ph_r == A_RUN || ph_r == A_POST)
                      && (!trans_store || differs);
        // Clock channel levels travel with the stored word
        sdata_nxt   = store_nxt ? data_m : sdata_r;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev_r    <= '0;
            ck_prev_r <= '0;
            store_r   <= 1'b0;
            sdata_r   <= '0;
        end else begin
            prev_r    <= prev_nxt;
            ck_prev_r <= ck_prev_nxt;
            store_r   <= store_nxt;
            sdata_r   <= sdata_nxt;
        end
    end

    assign store      = store_r;
    assign store_data = sdata_r;

    // ============================================================
    // Counter/timers
    for (genvar c = 0; c < N_CT; c++) begin : g_ct
        logic [CT_W-1:0] val_r;
        logic [CT_W-1:0] val_nxt;
        logic            run_r;
        logic            run_nxt;

        always_comb begin
            val_nxt = val_r;
            run_nxt = run_r;
            if (ct_timer[c]) begin
                if (act.start[c]) begin
                    run_nxt = 1'b1;
                end
                if (act.stop[c]) begin
                    run_nxt = 1'b0;
                end
                if (run_r) begin
                    val_nxt = val_r + 1'b1;
                end
            end else if (act.inc[c]) begin
                val_nxt = val_r + 1'b1;
            end
            if (act.set[c]) begin
                val_nxt = ct_preset[c];
            end
            // Reset wins over counting and leaves the run state alone
            if (act.rst[c]) begin
                val_nxt = '0;
            end
            if (ph_r != A_RUN && arm) begin
                val_nxt = '0;
                run_nxt = 1'b0;
            end
        end

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                val_r <= '0;
                run_r <= 1'b0;
            end else begin
                val_r <= val_nxt;
                run_r <= run_nxt;
            end
        end

        assign ct_hit[c] = (val_r >= ct_limit[c]);
        assign ct_val[c] = val_r;
    end
endmodule
`default_nettype wire

// file: testbench/ats_seq_asserts.sv
// Checker: timing relations among the sequencer's status outputs.
// Assumes a bind to the top module and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module ats_seq_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // Stimulus
    input wire logic       arm,
    input wire logic       smp_stb,
    input wire logic       async_mode,
    input wire logic       trig_in,
    input wire logic [2:0] n_range,
    // Status
    input wire logic       cfg_err,
    input wire logic       main_trig,
    input wire logic       hr_trig,
    input wire logic       acq_done,
    input wire logic [3:0] trig_state,
    input wire logic       store
);
    // ============================================================
    // Checks
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_MAIN_HOLD: assert property ($fell(main_trig) |-> $past(arm))
        else $error("main trigger fell without arm");
    AST_HR_CAUSE: assert property ($rose(hr_trig) |-> $past(trig_in))
        else $error("high-res trigger rose without trigger in");
    AST_HR_MAIN: assert property ($rose(hr_trig) |-> main_trig)
        else $error("trigger in left main trigger clear");
    AST_HR_HOLD: assert property (hr_trig && !arm |=> hr_trig)
        else $error("high-res trigger dropped");
    AST_STEP: assert property (async_mode && $past(async_mode) && $changed(trig_state)
        |-> $past(smp_stb) || $past(arm)) else $error("state moved without a sample");
    AST_STORE: assert property (async_mode && $past(async_mode) && store
        |-> $past(smp_stb)) else $error("store without a sample");
    AST_DONE_TRIG: assert property (acq_done |-> main_trig)
        else $error("done without main trigger");
    AST_CFG_RANGE: assert property (n_range > 3'h4 |-> cfg_err)
        else $error("range split not flagged");
    AST_ARM_CLEAR: assert property (arm && acq_done && !cfg_err |=> !acq_done && !main_trig)
        else $error("arm did not restart");
endmodule
`default_nettype wire

// file: testbench/ats_backplane_model.sv
// Backplane and acquisition memory stand-in: trigger in, store counting.
// Assumes bench requests change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module ats_backplane_model (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rstn,
    // Bench side
    input  wire logic   fire,
    input  wire logic   clr,
    // Design side
    input  wire logic   store,
    output logic        trig_in,
    output logic [1:0]  sig_in,
    output logic [15:0] n_stored
);
    // ============================================================
    // Backplane lines are registered and move on the rising edge after the bench strobe
    // Both signal lines follow the trigger line, so one strobe drives all three
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            {trig_in, sig_in} <= 3'h0;
        else
            {trig_in, sig_in} <= {3{fire}};
    end
    // Memory keeps only a count; the bench judges the data itself
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            n_stored <= 16'h0;
        else if (clr || store)
            n_stored <= clr ? 16'h0 : n_stored + 16'h1;
    end
endmodule
`default_nettype wire

// file: testbench/ats_trigger_sequencer_tb.sv
// Bench: sample-by-sample tests of the trigger sequencer.
// Assumes checker and backplane model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module ats_trigger_sequencer_tb;
    import ats_pkg::*;
    localparam ats_act_t TRG = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 1'h1};
    localparam logic [7:0] RX = 8'ha6, RM = 8'h60, RP = 8'h7f;
    localparam logic [DW-1:0] TOP = DW'(8'h10) | (DW'(1) << 184);
    // ============================================================
    // Signals
    logic             clk = 1'b0, rstn = 1'b0, smp_stb = 1'b0, async_mode = 1'b1;
    logic             merged = 1'b0, arm = 1'b0, fire = 1'b0, clr = 1'b0, trans_store = 1'b0;
    logic             trig_in, cfg_err, main_trig, hr_trig, acq_done, store;
    logic [DW-1:0]    smp_data = '0, slave_data = DW'(8'h18), store_data, rv [8];
    logic [N_GRP-1:0] grp_present = '1, glitch_en = '0, sh_en = '0, trans_en = '0;
    logic [N_GRP-1:0] zg = '0;
    logic [N_CK-1:0]  ck_en = '0;
    logic [2:0]       n_range = 3'h0;
    logic [1:0]       sig_use = 2'h0, sig_in;
    logic [3:0]       trig_pos = 4'h2, trig_state;
    logic [15:0]      n_stored;
    logic [CT_W-1:0]  ct_pre [N_CT], ct_val [N_CT], ta;
    ats_edge_t        ck_edge [N_CK];
    ats_word_t        word_cfg [N_WR];
    ats_rng_t         rng_cfg [N_RNG_MAX];
    ats_sh_t          sh_win [N_GRP];
    ats_prog_t        prog [N_ST];
    int               err_count = 0, num_checks = 0;

    ats_trigger_sequencer #(.POS_W(4)) ats_trigger_sequencer_i (
        .clk, .rstn, .smp_data, .smp_stb, .slave_data, .glitch_flag(zg), .sh_flag(zg),
        .async_mode, .merged, .grp_present, .ck_en, .ck_edge, .n_range, .word_cfg,
        .rng_cfg, .glitch_en, .sh_en, .sh_win, .trans_en, .sig_use, .prog, .trig_pos,
        .trans_store, .ct_timer(2'h2), .ct_preset(ct_pre), .ct_limit(ct_pre),
        .arm, .sig_in, .trig_in, .cfg_err, .main_trig, .hr_trig, .acq_done, .trig_state,
        .store, .store_data, .ct_val);
    ats_backplane_model ats_backplane_model_i (
        .clk, .rstn, .fire, .clr, .store, .trig_in, .sig_in, .n_stored);
    always #2.5 clk = ~clk;
    // ============================================================
    // Access tasks
    function automatic logic [DW-1:0] g5(input logic [7:0] v);
        return DW'(v) << 40;
    endfunction
    task automatic smp(input logic [DW-1:0] d);
        @(negedge clk);
        smp_data = d;
        smp_stb  = 1'b1;
        @(negedge clk);
        smp_stb  = 1'b0;
    endtask
    task automatic arm_it();
        @(negedge clk);
        {arm, clr} = 2'h3;
        @(negedge clk);
        {arm, clr} = 2'h0;
    endtask
    task automatic pulse();
        @(negedge clk);
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
    endtask
    task automatic blank();
        foreach (prog[i]) prog[i] = '{5'h1e, 4'(i), '0};
        n_range  = 3'h0;
        trans_en = '0;
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Trigger from the backplane, then feed samples until done or out of patience
    task automatic run_out();
        pulse();
        for (int k = 0; k < 40 && acq_done !== 1'b1; k++) smp('0);
        if (acq_done !== 1'b1) begin
            err_count++;
            print_verdict();
        end
    endtask
    // ============================================================
    // Tests
    initial begin
        foreach (ck_edge[i]) ck_edge[i] = EDGE_RISE;
        foreach (word_cfg[i]) word_cfg[i] = '0;
        foreach (rng_cfg[i]) rng_cfg[i] = '0;
        foreach (sh_win[i]) sh_win[i] = '0;
        foreach (ct_pre[i]) ct_pre[i] = '0;
        blank();
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        `CHK(trig_state, 4'h0)
        prog[0] = '{EV_TRUE, 4'h3, TRG};
        arm_it();
        smp(DW'(8'h0f));
        `CHK(trig_state, 4'h3)
        `CHK(main_trig, 1'b1)
        smp('0);
        smp('0);
        `CHK(acq_done, 1'b0)
        smp(DW'(8'h0a));
        `CHK(acq_done, 1'b1)
        `CHK(store_data, DW'(8'h0a))
        `CHK(hr_trig, 1'b0)
        @(negedge clk);
        `CHK(n_stored, 16'(trig_pos) + 16'h2)
        $display("Test walk done");
        blank();
        trans_en[5] = 1'b1;
        trans_store = 1'b1;
        word_cfg[0] = '{g5(8'h55), g5(8'hff)};
        prog[0] = '{5'h00, 4'h1, '0};
        prog[1] = '{EV_TRN, 4'h2, TRG};
        arm_it();
        smp(g5(8'h54));
        `CHK(trig_state, 4'h0)
        smp(g5(8'h55) | DW'(8'h01));
        `CHK(trig_state, 4'h1)
        smp(g5(8'h55));
        `CHK(trig_state, 4'h1)
        smp(g5(8'h57));
        `CHK(trig_state, 4'h2)
        run_out();
        `CHK(n_stored, 16'h5)
        trans_store = 1'b0;
        $display("Test word and transition done");
        blank();
        n_range = 3'h1;
        rng_cfg[0] = '{RW'(8'h10), RW'(8'h20)};
        prog[0] = '{EV_RNG0, 4'h1, TRG};
        // Order, merge and absent-group cases
        rv = '{DW'(8'h0f), DW'(8'h10), DW'(8'h20), DW'(8'h21), TOP, '0, DW'(1), TOP};
        for (int i = 0; i < 8; i++) begin
            merged = RM[i];
            grp_present[N_GRP-1] = RP[i];
            arm_it();
            smp(rv[i]);
            `CHK(main_trig, RX[i])
            run_out();
        end
        {merged, grp_present} = {1'b0, {N_GRP{1'b1}}};
        $display("Test range done");
        blank();
        prog[0] = '{EV_TRUE, 4'h1, '{2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 1'h0}};
        prog[1] = '{EV_TRUE, 4'h2, '{2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 1'h0}};
        prog[2] = '{EV_TRUE, 4'h3, '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 1'h0}};
        prog[3] = '{EV_TRUE, 4'h3, '{2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 1'h0}};
        ct_pre[0] = 51'h9;
        arm_it();
        smp('0);
        smp('0);
        `CHK(ct_val[0], 51'h2)
        ta = ct_val[1];
        repeat (4) @(negedge clk);
        `CHK(ct_val[1] - ta, 51'h4)
        smp('0);
        `CHK(ct_val[1] < 51'h3, 1'b1)
        ta = ct_val[1];
        repeat (4) @(negedge clk);
        `CHK(ct_val[1] - ta, 51'h4)
        smp('0);
        repeat (2) @(negedge clk);
        ta = ct_val[1];
        repeat (4) @(negedge clk);
        `CHK(ct_val[1], ta)
        `CHK(ct_val[0], 51'h9)
        run_out();
        blank();
        arm_it();
        pulse();
        @(negedge clk);
        `CHK(hr_trig, 1'b1)
        `CHK(main_trig, 1'b1)
        run_out();
        $display("Test counters and trigger in done");
        {async_mode, ck_en} = {1'b0, 4'h1};
        ck_edge[0] = EDGE_FALL;
        prog[0] = '{EV_TRUE, 4'h5, '0};
        arm_it();
        smp(DW'(1));
        @(negedge clk);
        `CHK(trig_state, 4'h0)
        smp('0);
        @(negedge clk);
        `CHK(trig_state, 4'h5)
        // Detector and backplane events; channel 0 falling makes each sync sample
        prog[5] = '{EV_SH, 4'h6, '0};
        prog[6] = '{EV_GLT, 4'h7, '0};
        prog[7] = '{EV_SIG1, 4'h8, '0};
        {sh_en[0], glitch_en[0], zg[0], sig_use} = 5'h1d;
        for (int i = 0; i < 2; i++) begin
            smp(DW'(1));
            smp('0);
            `CHK(trig_state, 4'h6)
        end
        async_mode = 1'b1;
        smp('0);
        `CHK(trig_state, 4'h7)
        fire = 1'b1;
        smp('0);
        fire = 1'b0;
        `CHK(trig_state, 4'h8)
        {sh_en[0], glitch_en[0], zg[0]} = 3'h0;
        n_range = 3'h5;
        @(negedge clk);
        `CHK(cfg_err, 1'b1)
        {n_range, sig_use, trans_en[0], glitch_en[0]} = {3'h4, 2'h3, 2'h3};
        @(negedge clk);
        `CHK(cfg_err, 1'b0)
        sh_en[0] = 1'b1;
        @(negedge clk);
        `CHK(cfg_err, 1'b1)
        {n_range, sh_win[0].setup} = {3'h0, 6'h21};
        @(negedge clk);
        `CHK(cfg_err, 1'b1)
        $display("Test sync clocking and limits done");
        print_verdict();
    end
endmodule
bind ats_trigger_sequencer ats_seq_asserts ats_seq_asserts_i (
    .clk(clk), .rstn(rstn), .arm(arm), .smp_stb(smp_stb), .async_mode(async_mode),
    .trig_in(trig_in), .n_range(n_range), .cfg_err(cfg_err), .main_trig(main_trig),
    .hr_trig(hr_trig), .acq_done(acq_done), .trig_state(trig_state), .store(store));
`default_nettype wire
